// >>> vis_consts.svh
// Purpose: Constants shared by both ends of the regulator serial link
// Assumes: 200 MHz ref_clk
// Notes: Glitch and settle cycle counts derive from times in ns
`ifndef VIS_CONSTS_SVH
`define VIS_CONSTS_SVH
`define VIS_CLK_MHZ 200
`define VIS_REG_VCODE 8'h00
`define VIS_REG_CTRL 8'h01
`define VIS_VCODE_RST 8'h32
`define VIS_CTRL_RST 8'h09
`define VIS_CTRL_MASK 8'h99
`define VIS_BIT_MODE 7
`define VIS_BIT_BYPASS 4
`define VIS_BIT_PWM 3
`define VIS_BIT_LATCH 0
`define VIS_UV_BASE 600000
`define VIS_UV_STEP 9375
`define VIS_UV_RST (`VIS_UV_BASE + 50 * `VIS_UV_STEP)
`define VIS_GLITCH_NS 32
`define VIS_GLITCH_CYC (`VIS_GLITCH_NS * `VIS_CLK_MHZ / 1000 + 2)
`define VIS_SETTLE_NS 15000
`define VIS_SETTLE_CYC (`VIS_SETTLE_NS * `VIS_CLK_MHZ / 1000)
`define VIS_SCL_KHZ 400
`define VIS_QTR_CYC (`VIS_CLK_MHZ * 1000 / (4 * `VIS_SCL_KHZ))
`define VIS_H_SADDR 3'h0
`define VIS_H_REGADDR 3'h1
`define VIS_H_WDATA 3'h2
`define VIS_H_CMD 3'h3
`define VIS_H_STATUS 3'h4
`define VIS_H_RDATA 3'h5
`endif

// >>> vis_i2c_if.sv
// Purpose: Open-drain two-wire link between controller and regulator
// Assumes: Pull-ups modelled as a wired AND
// Notes: Only the controller drives the clock wire
`timescale 1ns/1ps
`default_nettype none
interface vis_i2c_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;
    assign scl = m_scl_oe ? m_scl_o : 1'b1;
    assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
    modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
        input scl, sda);
    modport slave (output s_sda_o, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// >>> vis_i2c_properties.sv
// Purpose: Wire-level checks on the link joining both ends
// Assumes: One clock domain, ref_clk at 200 MHz
// Notes: Counters measure SCL phases in ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module vis_i2c_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Link drivers and wires
    input wire logic m_scl_o,
    input wire logic m_scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic [11:0] low_cnt;
    logic [11:0] hi_cnt;
    logic [11:0] per_cnt;
    // Saturate so an idle bus never wraps back to a small count
    function automatic logic [11:0] inc(input logic [11:0] c);
        return (c == 12'hfff) ? c : c + 12'h1;
    endfunction
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            low_cnt <= 12'hfff;
            hi_cnt <= 12'hfff;
            per_cnt <= 12'hfff;
        end else begin
            scl_q <= scl;
            low_cnt <= scl ? 12'h0 : inc(low_cnt);
            hi_cnt <= scl ? inc(hi_cnt) : 12'h0;
            per_cnt <= (scl && !scl_q) ? 12'h1 : inc(per_cnt);
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $rose(sda);
    endsequence
    a_open_drain_low: assert property (
        !m_scl_o && !m_sda_o && !s_sda_o)
        else $error("link driver drives a high level");
    a_reset_quiet: assert property (
        $rose(rstn) |-> !m_scl_oe && !m_sda_oe && !s_sda_oe)
        else $error("link driven right after reset");
    a_slave_window: assert property (
        $changed(s_sda_oe) |-> !scl && low_cnt <= 12'd40)
        else $error("slave changed SDA outside its window");
    a_bit_period: assert property (
        $rose(scl) |-> per_cnt >= 12'd495)
        else $error("SCL period below 2.5 us");
    a_scl_high: assert property (
        $fell(scl) |-> hi_cnt >= 12'd120)
        else $error("SCL high below 0.6 us");
    a_start_hold: assert property (
        s_start |-> scl [*8])
        else $error("SCL fell too soon after START");
    a_stop_idle: assert property (
        s_stop |-> (scl && sda) [*8])
        else $error("bus not free after STOP");
    a_data_stable: assert property (
        scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe))
        else $error("slave moved SDA while SCL high");
endmodule
`default_nettype wire

// >>> vis_i2c_slave_regs_tb.sv
// Purpose: Controller and regulator ends joined, driven from the port
// Assumes: Slave address 7'h36, 400 kHz link
// Notes: Each transfer takes up to some 15k cycles, so scenarios are few
`timescale 1ns/1ps
`default_nettype none
module vis_i2c_slave_regs_tb;
    localparam logic [6:0] SADDR = 7'h36;
    logic ref_clk, rstn, enable, vin_absent, vcc_uvlo, wr, rd;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, v;
    logic [6:0] code, code_q;
    logic par, imode, byp, pwm, latch, prot, scl_q, sda_q;
    logic [20:0] uv;
    logic [5:0] rises, hit;
    int mismatches, tests_run, cycles;
    vis_i2c_if link ();
    vis_master u_vis_master (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
    vis_slave #(.SLAVE_ADDR(SADDR)) u_vis_slave (.ref_clk(ref_clk),
        .rstn(rstn), .enable(enable), .vin_absent(vin_absent),
        .vcc_uvlo(vcc_uvlo), .link(link), .target_voltage_code(code),
        .voltage_id_parity(par), .internal_mode(imode), .prot_bypass(byp),
        .light_load_pwm_select(pwm), .latch_off_mode(latch),
        .protection_active(prot), .target_uv(uv));
    vis_i2c_properties u_vis_i2c_properties (.ref_clk(ref_clk),
        .rstn(rstn), .m_scl_o(link.m_scl_o), .m_scl_oe(link.m_scl_oe),
        .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
        .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe),
        .scl(link.scl), .sda(link.sda));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Counts SCL pulses since START and notes the pulse that moved the code
    always @(posedge ref_clk) begin
        scl_q <= link.scl;
        sda_q <= link.sda;
        code_q <= code;
        if (link.scl && sda_q && !link.sda) rises <= 6'h0;
        else if (link.scl && !scl_q) rises <= rises + 6'h1;
        if (code != code_q) hit <= rises;
        cycles = cycles + 1;
        if (cycles >= 100000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Flags expected are {data refused, address refused, done}
    task automatic xfer(input logic [6:0] sa, input logic [7:0] ra, d, cmd,
        input logic [2:0] flags);
        int n;
        n = 0;
        reg_wr(3'h0, {1'b0, sa});
        reg_wr(3'h1, ra);
        reg_wr(3'h2, d);
        reg_wr(3'h3, cmd);
        repeat (2) @(posedge ref_clk);
        v = 8'h01;
        while (v[0] === 1'b1 && n < 20000) begin
            reg_rd(3'h4, v);
            n++;
        end
        check("status", {29'h0, flags}, {29'h0, v[3:1]});
        check("busy", 32'h0, {31'h0, v[0]});
    endtask
    task automatic t_defaults;
        check("code", 32'h32, {25'h0, code});
        check("parity", 32'h0, {31'h0, par});
        check("mode", 32'h0, {31'h0, imode});
        check("bypass", 32'h0, {31'h0, byp});
        check("protect", 32'h1, {31'h0, prot});
        check("pwm", 32'h1, {31'h0, pwm});
        check("latch", 32'h1, {31'h0, latch});
        check("uv", 32'd1068750, {11'h0, uv});
    endtask
    task automatic t_read_code;
        xfer(SADDR, 8'h00, 8'h00, 8'h02, 3'b001);
        reg_rd(3'h5, v);
        check("read code", 32'h32, {24'h0, v});
    endtask
    task automatic t_write_code;
        xfer(SADDR, 8'h00, 8'hc1, 8'h01, 3'b001);
        check("code", 32'h41, {25'h0, code});
        check("parity", 32'h1, {31'h0, par});
        check("pulse", 32'd27, {26'h0, hit});
        check("uv", 32'd1209375, {11'h0, uv});
        // Bypass was set by t_control, so this code change lifts protection
        check("protect", 32'h0, {31'h0, prot});
        repeat (3000) @(posedge ref_clk);
        #1 check("protect", 32'h1, {31'h0, prot});
    endtask
    // Wrong parity and a foreign address must both leave the code alone
    task automatic t_refusals;
        xfer(SADDR, 8'h00, 8'h05, 8'h01, 3'b101);
        check("code kept", 32'h41, {25'h0, code});
        xfer(SADDR ^ 7'h01, 8'h00, 8'h80, 8'h01, 3'b011);
        check("code kept", 32'h41, {25'h0, code});
    endtask
    task automatic t_control;
        xfer(SADDR, 8'h01, 8'h91, 8'h01, 3'b001);
        check("mode", 32'h1, {31'h0, imode});
        check("bypass", 32'h1, {31'h0, byp});
        check("pwm", 32'h0, {31'h0, pwm});
        check("latch", 32'h1, {31'h0, latch});
        xfer(SADDR, 8'h00, 8'h00, 8'h02, 3'b001);
        reg_rd(3'h5, v);
        check("read ctrl", 32'h91, {24'h0, v});
        reg_rd(3'h6, v);
        check("unmapped", 32'h0, {24'h0, v});
    endtask
    task automatic t_power;
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            enable <= (i != 0);
            vin_absent <= (i == 1);
            vcc_uvlo <= (i == 2);
            repeat (6) @(posedge ref_clk);
            t_defaults();
            enable <= 1'b1;
            vin_absent <= 1'b0;
            vcc_uvlo <= 1'b0;
        end
    endtask
    initial begin
        {rstn, wr, rd, vin_absent, vcc_uvlo} = 5'h0;
        enable = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        {rises, hit, code_q} = '0;
        {scl_q, sda_q} = 2'b11;
        {mismatches, tests_run, cycles} = '0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1 t_defaults();
        t_read_code();
        t_control();
        t_write_code();
        t_refusals();
        t_power();
        end_of_test();
    end
endmodule
`default_nettype wire

// >>> vis_master.sv
// Purpose: Controller end: issues register writes and reads on the link
// Assumes: Slave never stretches the clock
// Notes: Clock made from ref_clk by a quarter-bit divider
`timescale 1ns/1ps
`default_nettype none
`include "vis_consts.svh"
module vis_master (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Link
    vis_i2c_if.master link
);
    vis_pkg::vis_host_t q;
    vis_pkg::vis_host_t n;
    logic tick;
    logic last_byte;
    logic rx_byte;

    assign link.m_scl_o = 1'b0;
    assign link.m_sda_o = 1'b0;
    assign link.m_scl_oe = q.scl_oe;
    assign link.m_sda_oe = q.sda_oe;
    assign rdata = q.rdout;

    always_comb begin
        n = q;
        tick = q.div == 7'h00;
        last_byte = q.byt == (q.rw ? 2'h1 : 2'h2);
        rx_byte = q.rw && q.byt == 2'h1;
        n.div = tick ? 7'(`VIS_QTR_CYC - 1) : q.div - 7'h01;
        n.sda_a = link.sda;
        n.sda_b = q.sda_a;
        if (rd) begin
            case (addr)
                `VIS_H_SADDR: n.rdout = {1'b0, q.saddr};
                `VIS_H_REGADDR: n.rdout = q.regaddr;
                `VIS_H_WDATA: n.rdout = q.wdata;
                `VIS_H_STATUS: n.rdout = {4'h0, q.nack_d, q.nack_a, q.done,
                    q.st != vis_pkg::HS_IDLE};
                `VIS_H_RDATA: n.rdout = q.rxdata;
                default: n.rdout = 8'h00;
            endcase
        end
        if (wr) begin
            case (addr)
                `VIS_H_SADDR: n.saddr = wdata[6:0];
                `VIS_H_REGADDR: n.regaddr = wdata;
                `VIS_H_WDATA: n.wdata = wdata;
                `VIS_H_CMD: begin
                    // Commands while busy are dropped
                    if (q.st == vis_pkg::HS_IDLE && wdata[1:0] != 2'h0) begin
                        n.st = vis_pkg::HS_START;
                        n.rw = wdata[1];
                        n.ph = 2'h0;
                        n.div = 7'(`VIS_QTR_CYC - 1);
                        n.done = 1'b0;
                        n.nack_a = 1'b0;
                        n.nack_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (tick && q.st != vis_pkg::HS_IDLE) begin
            n.ph = q.ph + 2'h1;
            case (q.st)
                vis_pkg::HS_START: begin
                    if (q.ph == 2'h0) begin
                        n.scl_oe = 1'b0;
                        n.sda_oe = 1'b0;
                    end else if (q.ph == 2'h2) begin
                        n.sda_oe = 1'b1;
                    end else if (q.ph == 2'h3) begin
                        n.scl_oe = 1'b1;
                        n.st = vis_pkg::HS_BIT;
                        n.byt = 2'h0;
                        n.slot = 4'h0;
                        n.shift = {q.saddr, q.rw};
                    end
                end
                vis_pkg::HS_BIT: begin
                    case (q.ph)
                        2'h0: n.sda_oe = q.slot == 4'h8 || rx_byte ? 1'b0
                            : !q.shift[7];
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.smp = q.sda_b;
                        default: begin
                            n.scl_oe = 1'b1;
                            if (q.slot != 4'h8) begin
                                n.shift = {q.shift[6:0], q.smp};
                                n.slot = q.slot + 4'h1;
                            end else if (!rx_byte && q.smp) begin
                                // Refused byte: flag it and send STOP, no retry
                                n.nack_a = q.byt == 2'h0;
                                n.nack_d = q.byt != 2'h0;
                                n.st = vis_pkg::HS_STOP;
                            end else if (last_byte) begin
                                if (rx_byte) begin
                                    n.rxdata = q.shift;
                                end
                                n.st = vis_pkg::HS_STOP;
                            end else begin
                                n.byt = q.byt + 2'h1;
                                n.slot = 4'h0;
                                n.shift = q.byt == 2'h0 ? q.regaddr : q.wdata;
                            end
                        end
                    endcase
                end
                vis_pkg::HS_STOP: begin
                    if (q.ph == 2'h0) begin
                        n.sda_oe = 1'b1;
                    end else if (q.ph == 2'h1) begin
                        n.scl_oe = 1'b0;
                    end else if (q.ph == 2'h2) begin
                        n.sda_oe = 1'b0;
                    end else begin
                        n.st = vis_pkg::HS_IDLE;
                        n.done = 1'b1;
                    end
                end
                default: n.st = vis_pkg::HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.st <= vis_pkg::HS_IDLE;
            q.sda_a <= 1'b1;
            q.sda_b <= 1'b1;
        end else begin
            q <= n;
        end
    end
endmodule
`default_nettype wire

// >>> vis_pkg.sv
// Purpose: Types for the regulator serial link ends
// Assumes: Nothing
// Notes: State of each end is one packed struct
package vis_pkg;
    typedef enum logic [3:0] {DS_IDLE, DS_ADDR, DS_AACK, DS_REG, DS_RACK,
        DS_WDATA, DS_WACK, DS_RDATA, DS_SKIP} vis_dev_state_t;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP}
        vis_host_state_t;
    typedef struct packed {
        logic clr_a;
        logic clr_b;
        logic scl_a;
        logic scl_b;
        logic sda_a;
        logic sda_b;
        logic scl_f;
        logic sda_f;
        logic [3:0] scl_cnt;
        logic [3:0] sda_cnt;
        vis_dev_state_t st;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic rw;
        logic ptr;
        logic sda_oe;
        logic [7:0] vcode;
        logic [7:0] ctrl;
        logic [11:0] settle;
        logic prot_off;
        logic [20:0] uv;
    } vis_dev_t;
    typedef struct packed {
        vis_host_state_t st;
        logic [1:0] ph;
        logic [6:0] div;
        logic [3:0] slot;
        logic [1:0] byt;
        logic rw;
        logic [7:0] shift;
        logic smp;
        logic scl_oe;
        logic sda_oe;
        logic sda_a;
        logic sda_b;
        logic [6:0] saddr;
        logic [7:0] regaddr;
        logic [7:0] wdata;
        logic [7:0] rxdata;
        logic done;
        logic nack_a;
        logic nack_d;
        logic [7:0] rdout;
    } vis_host_t;
endpackage

// >>> vis_slave.sv
// Purpose: Regulator end: serial slave with voltage code and control byte
// Assumes: Link pins asynchronous to ref_clk, sampled through two flops
// Notes: Analog loop lives outside; this block only holds its settings
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "vis_consts.svh"
module vis_slave #(
    // Arbitrary value; real parts strap their own
    parameter logic [6:0] SLAVE_ADDR = 7'h36
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Power conditions, asynchronous levels
    input wire logic enable,
    input wire logic vin_absent,
    input wire logic vcc_uvlo,
    // Link
    vis_i2c_if.slave link,
    // Settings towards the regulator core
    output logic [6:0] target_voltage_code,
    output logic voltage_id_parity,
    output logic internal_mode,
    output logic prot_bypass,
    output logic light_load_pwm_select,
    output logic latch_off_mode,
    output logic protection_active,
    output logic [20:0] target_uv
);
    vis_pkg::vis_dev_t q;
    vis_pkg::vis_dev_t n;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_ok;
    logic [7:0] rd_val;

    assign link.s_sda_o = 1'b0;
    assign link.s_sda_oe = q.sda_oe;
    assign target_voltage_code = q.vcode[6:0];
    assign voltage_id_parity = q.vcode[7];
    assign internal_mode = q.ctrl[`VIS_BIT_MODE];
    assign prot_bypass = q.ctrl[`VIS_BIT_BYPASS];
    assign light_load_pwm_select = q.ctrl[`VIS_BIT_PWM];
    assign latch_off_mode = q.ctrl[`VIS_BIT_LATCH];
    assign protection_active = !q.prot_off;
    assign target_uv = q.uv;

    always_comb begin
        n = q;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_det = 1'b0;
        stop_det = 1'b0;
        byte_ok = 1'b0;
        rd_val = q.ptr ? q.ctrl : q.vcode;
        // Two-flop synchronisers; first stage feeds only the second
        n.clr_a = !enable || vin_absent || vcc_uvlo;
        n.clr_b = q.clr_a;
        n.scl_a = link.scl;
        n.scl_b = q.scl_a;
        n.sda_a = link.sda;
        n.sda_b = q.sda_a;
        // A level must hold longer than the spike limit to be taken
        if (q.scl_b != q.scl_f) begin
            n.scl_cnt = q.scl_cnt + 4'h1;
            if (q.scl_cnt == 4'(`VIS_GLITCH_CYC - 1)) begin
                n.scl_f = q.scl_b;
                n.scl_cnt = 4'h0;
            end
        end else begin
            n.scl_cnt = 4'h0;
        end
        if (q.sda_b != q.sda_f) begin
            n.sda_cnt = q.sda_cnt + 4'h1;
            if (q.sda_cnt == 4'(`VIS_GLITCH_CYC - 1)) begin
                n.sda_f = q.sda_b;
                n.sda_cnt = 4'h0;
            end
        end else begin
            n.sda_cnt = 4'h0;
        end
        scl_rise = !q.scl_f && n.scl_f;
        scl_fall = q.scl_f && !n.scl_f;
        start_det = q.scl_f && n.scl_f && q.sda_f && !n.sda_f;
        stop_det = q.scl_f && n.scl_f && !q.sda_f && n.sda_f;
        if (q.ptr) begin
            byte_ok = (q.shift & ~`VIS_CTRL_MASK) == 8'h00;
        end else begin
            byte_ok = q.shift[7] == ~^q.shift[6:0];
        end
        if (q.settle != 12'h000) begin
            n.settle = q.settle - 12'h001;
        end
        // Any bit edge: shift in on rise for receive states
        if (scl_rise && (q.st == vis_pkg::DS_ADDR || q.st == vis_pkg::DS_REG
                || q.st == vis_pkg::DS_WDATA)) begin
            n.shift = {q.shift[6:0], q.sda_f};
            n.cnt = q.cnt + 4'h1;
        end
        if (q.clr_b) begin
            // Settings fall back while power is not good
            n.st = vis_pkg::DS_IDLE;
            n.sda_oe = 1'b0;
            n.vcode = `VIS_VCODE_RST;
            n.ctrl = `VIS_CTRL_RST;
            n.ptr = 1'b0;
            n.settle = 12'h000;
        end else if (start_det) begin
            n.st = vis_pkg::DS_ADDR;
            n.cnt = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_det) begin
            n.st = vis_pkg::DS_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (q.st)
                vis_pkg::DS_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                vis_pkg::DS_ADDR: begin
                    if (scl_fall && q.cnt == 4'h8) begin
                        if (q.shift[7:1] == SLAVE_ADDR) begin
                            n.sda_oe = 1'b1;
                            n.rw = q.shift[0];
                            n.st = vis_pkg::DS_AACK;
                        end else begin
                            n.st = vis_pkg::DS_SKIP;
                        end
                    end
                end
                vis_pkg::DS_AACK: begin
                    if (scl_fall) begin
                        n.cnt = 4'h0;
                        if (q.rw) begin
                            n.shift = rd_val;
                            n.sda_oe = !rd_val[7];
                            n.st = vis_pkg::DS_RDATA;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.st = vis_pkg::DS_REG;
                        end
                    end
                end
                vis_pkg::DS_REG: begin
                    if (scl_fall && q.cnt == 4'h8) begin
                        if (q.shift == `VIS_REG_VCODE
                                || q.shift == `VIS_REG_CTRL) begin
                            n.ptr = q.shift[0];
                            n.sda_oe = 1'b1;
                            n.st = vis_pkg::DS_RACK;
                        end else begin
                            n.st = vis_pkg::DS_SKIP;
                        end
                    end
                end
                vis_pkg::DS_RACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.cnt = 4'h0;
                        n.st = vis_pkg::DS_WDATA;
                    end
                end
                vis_pkg::DS_WDATA: begin
                    if (scl_fall && q.cnt == 4'h8) begin
                        if (byte_ok) begin
                            n.sda_oe = 1'b1;
                            n.st = vis_pkg::DS_WACK;
                        end else begin
                            n.st = vis_pkg::DS_SKIP;
                        end
                    end
                end
                vis_pkg::DS_WACK: begin
                    // Load on the rise of the ack pulse, pulse 27
                    if (scl_rise) begin
                        if (q.ptr) begin
                            n.ctrl = q.shift & `VIS_CTRL_MASK;
                        end else begin
                            n.vcode = q.shift;
                            if (q.shift[6:0] != q.vcode[6:0]) begin
                                n.settle = 12'(`VIS_SETTLE_CYC);
                            end
                        end
                    end
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.st = vis_pkg::DS_SKIP;
                    end
                end
                vis_pkg::DS_RDATA: begin
                    if (scl_rise) begin
                        n.cnt = q.cnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (q.cnt == 4'h8) begin
                            // Master ack is not examined
                            n.sda_oe = 1'b0;
                            n.st = vis_pkg::DS_SKIP;
                        end else begin
                            n.shift = {q.shift[6:0], 1'b0};
                            n.sda_oe = !q.shift[6];
                        end
                    end
                end
                vis_pkg::DS_SKIP: begin
                    n.sda_oe = 1'b0;
                end
                default: begin
                    n.st = vis_pkg::DS_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
        n.prot_off = n.ctrl[`VIS_BIT_BYPASS] && n.settle != 12'h000;
        n.uv = 21'(`VIS_UV_BASE)
            + 21'(n.vcode[6:0]) * 21'(`VIS_UV_STEP);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.scl_a <= 1'b1;
            q.scl_b <= 1'b1;
            q.sda_a <= 1'b1;
            q.sda_b <= 1'b1;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            q.st <= vis_pkg::DS_IDLE;
            q.vcode <= `VIS_VCODE_RST;
            q.ctrl <= `VIS_CTRL_RST;
            q.uv <= 21'(`VIS_UV_RST);
        end else begin
            q <= n;
        end
    end
endmodule
`default_nettype wire
